// File: src/ape_pkg.sv
// constants shared by the active power and energy datapath
package ape_pkg;

    // ========================================================
    // widths
    localparam int unsigned ADDR_W     = 6;
    localparam int unsigned DATA_W     = 24;
    localparam int unsigned CUR_W      = 24;
    localparam int unsigned VOLT_W     = 16;
    localparam int unsigned POWER_W    = 24;
    localparam int unsigned FRAC_W     = 33;
    localparam int unsigned ACC_W      = 49;
    localparam int unsigned ENERGY_W   = 24;
    localparam int unsigned GAIN_W     = 12;
    localparam int unsigned OFFSET_W   = 16;
    localparam int unsigned DIV_W      = 8;
    localparam int unsigned MODE_W     = 16;
    localparam int unsigned FLAG_W     = 8;

    // ========================================================
    // register indices on the register port
    localparam logic [5:0] REG_WAVEFORM      = 6'h01;
    localparam logic [5:0] REG_ACTIVE_ENERGY = 6'h02;
    localparam logic [5:0] REG_ENERGY_COR    = 6'h03;
    localparam logic [5:0] REG_MODE          = 6'h09;
    localparam logic [5:0] REG_IRQ_ENABLE    = 6'h0A;
    localparam logic [5:0] REG_STATUS        = 6'h0B;
    localparam logic [5:0] REG_POWER_OFFSET  = 6'h11;
    localparam logic [5:0] REG_WATT_GAIN     = 6'h12;
    localparam logic [5:0] REG_ENERGY_DIV    = 6'h13;

    // ========================================================
    // fields and reset values
    localparam int unsigned MODE_POS_ONLY_BIT = 15;
    localparam int unsigned MODE_SRC_LSB      = 13;
    localparam int unsigned MODE_RATE_LSB     = 11;
    localparam logic [1:0]  WAVE_SRC_POWER    = 2'h0;
    localparam int unsigned FLAG_HALF_BIT     = 0;
    localparam int unsigned FLAG_WRAP_BIT     = 1;
    localparam int unsigned FLAG_SAMPLE_BIT   = 3;
    localparam logic [15:0] MODE_RESET        = 16'h0000;
    localparam logic [7:0]  IRQ_EN_RESET      = 8'h00;
    localparam logic [11:0] GAIN_RESET        = 12'h000;
    localparam logic [15:0] OFFSET_RESET      = 16'h0000;
    localparam logic [7:0]  DIV_RESET         = 8'h00;

    // ========================================================
    // arithmetic scaling and timing counts
    localparam int unsigned GAIN_FRAC_BITS    = 12;
    localparam int unsigned OFFSET_FRAC_BITS  = 8;
    localparam int unsigned PROD_SHIFT        = 16;
    localparam int unsigned LPF_SHIFT         = 10;
    localparam int unsigned ACC_TICK_CYCLES   = 4;
    localparam int unsigned WAVE_BASE_TICKS   = 32;

endpackage : ape_pkg

// File: src/ape_energy_acc.sv
// 49-bit signed energy accumulator with clear-on-read and wrap events
`timescale 1ns/100ps

module ape_energy_acc #(
    parameter int unsigned TERM_W = 33
) (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    tick,
    input  wire logic signed [TERM_W-1:0] term,
    input  wire logic                    clear_upper,
    output logic        [23:0]           energy,
    output logic                         half_evt,
    output logic                         wrap_evt
);

    localparam int unsigned AW = ape_pkg::ACC_W;
    localparam int unsigned EW = ape_pkg::ENERGY_W;

    if (TERM_W < 2 || TERM_W >= AW) begin : g_bad_term
        $error("ape_energy_acc: TERM_W out of range");
    end

    logic signed [AW-1:0] acc_q;
    logic signed [AW-1:0] acc_d;
    logic signed [AW-1:0] base;
    logic                 half_q;
    logic                 half_d;
    logic                 wrap_q;
    logic                 wrap_d;
    logic        [EW-1:0] old_e;
    logic        [EW-1:0] new_e;

    // ========================================================
    // accumulate
    always_comb begin
        base = acc_q;
        if (clear_upper) begin
            base[AW-1:AW-EW] = '0;                              // [RL9]
        end
        acc_d  = base;
        half_d = 1'b0;
        wrap_d = 1'b0;
        old_e  = base[AW-1:AW-EW];
        if (tick) begin
            // plain two's complement add, wraps at full scale
            acc_d = base + AW'(term);                      // [RL3] [RL5] [RL11]
        end
        new_e = acc_d[AW-1:AW-EW];
        if (tick) begin
            // half-full: moving outward past one half of full scale, positive or negative
            half_d = (old_e[EW-1:EW-2] == 2'b00 && new_e[EW-1:EW-2] == 2'b01)
                  || (old_e[EW-1:EW-2] == 2'b11 && new_e[EW-1:EW-2] == 2'b10);
            wrap_d = (!old_e[EW-1] && new_e[EW-1] && !term[TERM_W-1])
                  || (old_e[EW-1] && !new_e[EW-1] && term[TERM_W-1]); // [RL12]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q  <= '0;                                        // [RL16]
            half_q <= 1'b0;
            wrap_q <= 1'b0;
        end else begin
            acc_q  <= acc_d;
            half_q <= half_d;
            wrap_q <= wrap_d;
        end
    end

    assign energy   = acc_q[AW-1:AW-EW];                         // [RL3]
    assign half_evt = half_q;
    assign wrap_evt = wrap_q;

endmodule : ape_energy_acc

// File: src/ape_top.sv
// active power datapath, energy accumulation and register port
`timescale 1ns/100ps

// How it works
// [RL1] multiply current and voltage samples, low-pass the product into active power
// [RL2] scale active power by one plus signed 12-bit watt gain over 4096
// [RL3] accumulate into 49-bit signed register; readable energy is upper 24 bits
// [RL4] add one power sample to the accumulator every four input clocks
// [RL5] accumulation is a signed add so negative power lowers the total
// [RL6] positive-only mode discards negative samples before accumulation
// [RL7] divide by unsigned 8-bit energy divider; zero acts as one
// [RL8] fill time grows in proportion to a nonzero divider setting
// [RL9] clear-on-read energy read returns energy and clears accumulator upper bits
// [RL10] source 0,0 plus sample enable bit 3 puts power in waveform register
// [RL11] energy wraps with two's complement behaviour at both full scales
// [RL12] half-full and overflow/underflow raise enableable interrupt events
// [RL13] signed 16-bit power offset added at 1/256 of a waveform LSB
// [RL14] mode bit 15 selects positive-only accumulation, off after reset
// [RL15] interrupt request goes low when a new waveform sample is ready
// [RL16] reset clears the accumulator and all pending event flags
module ape_top #(
    parameter int unsigned LPF_SHIFT       = ape_pkg::LPF_SHIFT,
    parameter int unsigned WAVE_BASE_TICKS = ape_pkg::WAVE_BASE_TICKS
) (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic signed [23:0]         current_sample,
    input  wire logic signed [15:0]         voltage_sample,
    input  wire logic        [5:0]          reg_addr,
    input  wire logic                       reg_wr,
    input  wire logic        [23:0]         reg_wdata,
    input  wire logic                       reg_rd,
    output logic             [23:0]         reg_rdata,
    output logic                            reg_rvalid,
    output logic                            irq_n
);

    localparam int unsigned PW = ape_pkg::POWER_W;
    localparam int unsigned FW = ape_pkg::FRAC_W;
    localparam int unsigned PRW = ape_pkg::CUR_W + ape_pkg::VOLT_W;
    localparam int unsigned GPW = PW + ape_pkg::GAIN_W;
    localparam int unsigned WCW = 12;

    if (LPF_SHIFT < 1 || LPF_SHIFT > 20) begin : g_bad_lpf
        $error("ape_top: LPF_SHIFT out of range");
    end
    if (WAVE_BASE_TICKS < 1 || WAVE_BASE_TICKS * 8 > 4095) begin : g_bad_wave
        $error("ape_top: WAVE_BASE_TICKS out of range");
    end

    // ========================================================
    // accumulation tick
    logic [1:0] tick_cnt_q;
    logic [1:0] tick_cnt_d;
    logic       tick;

    always_comb begin
        tick       = (tick_cnt_q == 2'(ape_pkg::ACC_TICK_CYCLES - 1)); // [RL4]
        tick_cnt_d = tick ? 2'h0 : tick_cnt_q + 2'h1;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_q <= 2'h0;
        end else begin
            tick_cnt_q <= tick_cnt_d;
        end
    end

    // ========================================================
    // control registers
    logic        [15:0] mode_q;
    logic        [15:0] mode_d;
    logic        [7:0]  irq_en_q;
    logic        [7:0]  irq_en_d;
    logic signed [11:0] gain_q;
    logic signed [11:0] gain_d;
    logic signed [15:0] offset_q;
    logic signed [15:0] offset_d;
    logic        [7:0]  div_q;
    logic        [7:0]  div_d;

    always_comb begin
        mode_d   = mode_q;
        irq_en_d = irq_en_q;
        gain_d   = gain_q;
        offset_d = offset_q;
        div_d    = div_q;
        if (reg_wr) begin
            unique case (reg_addr)
                ape_pkg::REG_MODE:         mode_d   = reg_wdata[15:0];
                ape_pkg::REG_IRQ_ENABLE:   irq_en_d = reg_wdata[7:0];
                ape_pkg::REG_WATT_GAIN:    gain_d   = reg_wdata[11:0];
                ape_pkg::REG_POWER_OFFSET: offset_d = reg_wdata[15:0];
                ape_pkg::REG_ENERGY_DIV:   div_d    = reg_wdata[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q   <= ape_pkg::MODE_RESET;                    // [RL14]
            irq_en_q <= ape_pkg::IRQ_EN_RESET;
            gain_q   <= ape_pkg::GAIN_RESET;
            offset_q <= ape_pkg::OFFSET_RESET;
            div_q    <= ape_pkg::DIV_RESET;
        end else begin
            mode_q   <= mode_d;
            irq_en_q <= irq_en_d;
            gain_q   <= gain_d;
            offset_q <= offset_d;
            div_q    <= div_d;
        end
    end

    // ========================================================
    // multiplier and low-pass
    logic signed [PRW-1:0] prod;
    logic signed [PW-1:0]  prod_s;
    logic signed [PW:0]    lpf_diff;
    logic signed [PW:0]    lpf_step;
    logic signed [PW:0]    lpf_sum;
    logic signed [PW-1:0]  lpf_q;
    logic signed [PW-1:0]  lpf_d;

    always_comb begin
        prod     = current_sample * voltage_sample;             // [RL1]
        prod_s   = prod[PRW-1:ape_pkg::PROD_SHIFT];
        lpf_diff = (PW+1)'(prod_s) - (PW+1)'(lpf_q);
        // first order filter: ripple at twice line rate remains
        lpf_step = lpf_diff >>> LPF_SHIFT;
        lpf_sum  = (PW+1)'(lpf_q) + lpf_step;
        lpf_d    = tick ? lpf_sum[PW-1:0] : lpf_q;              // [RL1]
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lpf_q <= '0;
        end else begin
            lpf_q <= lpf_d;
        end
    end

    // ========================================================
    // gain, offset, divider, positive-only gate
    logic signed [GPW-1:0] gain_prod;
    logic signed [PW:0]    power_g;
    logic signed [FW-1:0]  power_frac;
    logic        [7:0]     div_eff;
    logic signed [FW-1:0]  quot;
    logic signed [FW-1:0]  term;
    logic signed [PW-1:0]  wave_value;

    always_comb begin
        gain_prod  = lpf_q * gain_q;
        power_g    = (PW+1)'(lpf_q) + (PW+1)'($signed(
                     gain_prod[GPW-1:ape_pkg::GAIN_FRAC_BITS])); // [RL2]
        power_frac = {power_g, 8'h00} + FW'(offset_q);          // [RL13]
        // keeps 24 bits: values beyond 24-bit full scale are not expected
        wave_value = power_frac[FW-2:ape_pkg::OFFSET_FRAC_BITS];
        div_eff    = (div_q == 8'h00) ? 8'h01 : div_q;          // [RL7]
        // remainder dropped each tick, so fill time scales by the divider
        quot       = power_frac / $signed({1'b0, div_eff});     // [RL7] [RL8]
        term       = quot;
        if (mode_q[ape_pkg::MODE_POS_ONLY_BIT] && quot[FW-1]) begin
            term = '0;                                          // [RL6] [RL14]
        end
    end

    // ========================================================
    // energy accumulator
    logic [23:0] energy;
    logic        half_evt;
    logic        wrap_evt;
    logic        clear_upper;

    assign clear_upper = reg_rd && (reg_addr == ape_pkg::REG_ENERGY_COR);

    ape_energy_acc #(
        .TERM_W      (FW)
    ) u_acc (
        .clk         (clk),
        .rst_n       (rst_n),
        .tick        (tick),
        .term        (term),
        .clear_upper (clear_upper),
        .energy      (energy),
        .half_evt    (half_evt),
        .wrap_evt    (wrap_evt)
    );

    // ========================================================
    // waveform sampling
    logic [WCW-1:0] wave_cnt_q;
    logic [WCW-1:0] wave_cnt_d;
    logic [WCW-1:0] wave_period;
    logic [23:0]    wave_q;
    logic [23:0]    wave_d;
    logic           sample_evt;
    logic           wave_on;

    always_comb begin
        wave_period = WCW'(WAVE_BASE_TICKS)
                    << mode_q[ape_pkg::MODE_RATE_LSB +: 2];
        wave_on     = (mode_q[ape_pkg::MODE_SRC_LSB +: 2]
                       == ape_pkg::WAVE_SRC_POWER)
                   && irq_en_q[ape_pkg::FLAG_SAMPLE_BIT];       // [RL10]
        wave_cnt_d  = wave_cnt_q;
        wave_d      = wave_q;
        sample_evt  = 1'b0;
        if (!wave_on) begin
            wave_cnt_d = '0;
        end else if (tick) begin
            if (wave_cnt_q >= wave_period - WCW'(1)) begin
                wave_cnt_d = '0;
                wave_d     = wave_value;                        // [RL10]
                sample_evt = 1'b1;
            end else begin
                wave_cnt_d = wave_cnt_q + WCW'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wave_cnt_q <= '0;
            wave_q     <= '0;
        end else begin
            wave_cnt_q <= wave_cnt_d;
            wave_q     <= wave_d;
        end
    end

    // ========================================================
    // status flags, set wins over clear-on-read
    logic [7:0] flags_q;
    logic [7:0] flags_d;
    logic [7:0] flag_set;

    always_comb begin
        flag_set = 8'h00;
        flag_set[ape_pkg::FLAG_HALF_BIT]   = half_evt;          // [RL12]
        flag_set[ape_pkg::FLAG_WRAP_BIT]   = wrap_evt;          // [RL12]
        flag_set[ape_pkg::FLAG_SAMPLE_BIT] = sample_evt;
        flags_d = flags_q;
        if (reg_rd && reg_addr == ape_pkg::REG_STATUS) begin
            flags_d = 8'h00;
        end
        flags_d = flags_d | flag_set;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= 8'h00;                                   // [RL16]
        end else begin
            flags_q <= flags_d;
        end
    end

    // open-drain style request, low while an enabled flag is pending
    assign irq_n = ~|(flags_q & irq_en_q);                      // [RL12] [RL15]

    // ========================================================
    // register read port
    logic [23:0] rdata_q;
    logic [23:0] rdata_d;
    logic        rvalid_q;

    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd) begin
            unique case (reg_addr)
                ape_pkg::REG_WAVEFORM:      rdata_d = wave_q;
                ape_pkg::REG_ACTIVE_ENERGY: rdata_d = energy;
                ape_pkg::REG_ENERGY_COR:    rdata_d = energy;   // [RL9]
                ape_pkg::REG_MODE:          rdata_d = {8'h00, mode_q};
                ape_pkg::REG_IRQ_ENABLE:    rdata_d = {16'h0000, irq_en_q};
                ape_pkg::REG_STATUS:        rdata_d = {16'h0000, flags_q};
                ape_pkg::REG_POWER_OFFSET:  rdata_d = {8'h00, offset_q};
                ape_pkg::REG_WATT_GAIN:     rdata_d = {12'h000, gain_q};
                ape_pkg::REG_ENERGY_DIV:    rdata_d = {16'h0000, div_q};
                default:                    rdata_d = 24'h00_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q  <= 24'h00_0000;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= reg_rd;
        end
    end

    assign reg_rdata  = rdata_q;
    assign reg_rvalid = rvalid_q;

endmodule : ape_top

// File: verification/ape_monitor.sv
// assertions on the register port and interrupt line of ape_top
`timescale 1ns/100ps

module ape_monitor (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [5:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic [23:0] reg_wdata,
    input wire logic        reg_rd,
    input wire logic [23:0] reg_rdata,
    input wire logic        reg_rvalid,
    input wire logic        irq_n
);
    // ========================================================
    // tick phase: edges since reset release, modulo four
    logic [1:0] ph_q;
    logic [1:0] ph_d;

    always_comb begin
        ph_d = ph_q + 2'h1;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ph_q <= 2'h0;
        end else begin
            ph_q <= ph_d;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ========================================================
    // write, one idle cycle, then read of the same index
    property rb_p(logic [5:0] a, logic [23:0] m);
        (reg_wr && reg_addr == a) ##1 !reg_wr
            ##1 (reg_rd && !reg_wr && reg_addr == a)
            |=> reg_rdata == ($past(reg_wdata, 3) & m);
    endproperty

    gain_rb_a: assert property (
        rb_p(ape_pkg::REG_WATT_GAIN, 24'h00_0fff))
        else $error("watt gain readback wrong");
    offset_rb_a: assert property (
        rb_p(ape_pkg::REG_POWER_OFFSET, 24'h00_ffff))
        else $error("power offset readback wrong");
    div_rb_a: assert property (
        rb_p(ape_pkg::REG_ENERGY_DIV, 24'h00_00ff))
        else $error("energy divider readback wrong");
    mode_rb_a: assert property (
        rb_p(ape_pkg::REG_MODE, 24'h00_ffff))
        else $error("mode readback wrong");
    cor_answer_a: assert property (
        (reg_rd && reg_addr == ape_pkg::REG_ENERGY_COR) |=> reg_rvalid)
        else $error("clear-on-read energy read not answered");
    rdata_hold_a: assert property (
        !reg_rvalid |-> $stable(reg_rdata))
        else $error("read data moved without a read");
    reset_irq_a: assert property (
        $rose(rst_n) |-> irq_n [*3])
        else $error("interrupt pending right after reset");
    status_nz_a: assert property (
        (reg_rd && reg_addr == ape_pkg::REG_STATUS && !irq_n)
        |=> reg_rdata != 24'h00_0000)
        else $error("status empty while interrupt low");
    // flags only land on the tick edge or one edge later
    irq_phase_a: assert property (
        ($fell(irq_n) && !$past(reg_wr)) |-> ph_q[1] == 1'b0)
        else $error("interrupt fell off the tick phase");

    cover property (reg_rd && reg_addr == ape_pkg::REG_ENERGY_COR);
    cover property ($fell(irq_n));
    cover property (reg_rd && reg_addr == ape_pkg::REG_STATUS && !irq_n);

endmodule : ape_monitor

bind ape_top ape_monitor i_mon (
    .clk        (clk),
    .rst_n      (rst_n),
    .reg_addr   (reg_addr),
    .reg_wr     (reg_wr),
    .reg_wdata  (reg_wdata),
    .reg_rd     (reg_rd),
    .reg_rdata  (reg_rdata),
    .reg_rvalid (reg_rvalid),
    .irq_n      (irq_n)
);

// File: verification/ape_host.sv
// host model issuing register reads and writes
`timescale 1ns/100ps

module ape_host (
    input  wire logic        clk,
    output logic      [5:0]  reg_addr,
    output logic             reg_wr,
    output logic      [23:0] reg_wdata,
    output logic             reg_rd,
    input  wire logic [23:0] reg_rdata,
    input  wire logic        reg_rvalid
);
    initial begin
        reg_addr  = 6'h3f;
        reg_wr    = 1'b0;
        reg_wdata = 24'h00_0000;
        reg_rd    = 1'b0;
    end

    // released lines carry the inverse so stale values never look valid
    task automatic wr(input logic [5:0] a, input logic [23:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask : wr

    task automatic rd(input logic [5:0] a, output logic [23:0] q,
                      output bit ok);
        ok = 1'b0;
        q  = 24'h00_0000;
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        for (int k = 0; k < 4 && !ok; k++) begin
            #1;
            if (reg_rvalid === 1'b1) begin
                q  = reg_rdata;
                ok = 1'b1;
            end else begin
                @(posedge clk);
            end
        end
    endtask : rd

endmodule : ape_host

// File: verification/tb.sv
// self-checking testbench for the active power and energy datapath
`timescale 1ns/100ps

`define CHECK(g, e) begin n_compared++; if ((g) !== (e)) begin \
    fail_count++; $display("CHECK FAILED %0t got %h exp %h", $time, g, e); \
    end end

module tb;
    logic               clk            = 1'b0;
    logic               rst_n          = 1'b0;
    logic signed [23:0] current_sample = 24'sh00_0000;
    logic signed [15:0] voltage_sample = 16'sh0000;
    logic        [5:0]  reg_addr;
    logic               reg_wr;
    logic        [23:0] reg_wdata;
    logic               reg_rd;
    logic        [23:0] reg_rdata;
    logic               reg_rvalid;
    logic               irq_n;
    int                 fail_count     = 0;
    int                 n_compared     = 0;

    always #4 clk = ~clk;

    // short filter and one-tick waveform period keep the run brief
    ape_top #(.LPF_SHIFT(2), .WAVE_BASE_TICKS(1)) i_dut (
        .clk(clk), .rst_n(rst_n), .current_sample(current_sample),
        .voltage_sample(voltage_sample), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .irq_n(irq_n));

    ape_host i_host (
        .clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid));

    // ========================================================
    // helpers
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize

    task automatic rd(input logic [5:0] a, output logic [23:0] q);
        bit ok;
        i_host.rd(a, q, ok);
        if (!ok) begin
            fail_count++;
            $display("CHECK FAILED %0t no read answer", $time);
            summarize();
        end
    endtask : rd

    task automatic wait_irq;
        for (int k = 0; k < 40; k++) begin
            @(posedge clk);
            #1;
            if (irq_n === 1'b0) return;
        end
        fail_count++;
        $display("CHECK FAILED %0t no interrupt", $time);
        summarize();
    endtask : wait_irq

    function automatic logic in_rng(logic [23:0] v, longint lo, longint hi);
        return longint'(v) >= lo && longint'(v) <= hi;
    endfunction : in_rng

    function automatic longint scale(longint l, logic [11:0] g);
        return l + ((l * longint'($signed(g))) >>> 12);
    endfunction : scale

    // ========================================================
    // scenarios
    task automatic t_reset;
        logic [5:0]  a [10];
        logic [23:0] q;
        a = '{ape_pkg::REG_MODE, ape_pkg::REG_IRQ_ENABLE,
              ape_pkg::REG_STATUS, ape_pkg::REG_POWER_OFFSET,
              ape_pkg::REG_WATT_GAIN, ape_pkg::REG_ENERGY_DIV,
              ape_pkg::REG_ACTIVE_ENERGY, ape_pkg::REG_ENERGY_COR,
              ape_pkg::REG_WAVEFORM, 6'h3f};
        `CHECK(irq_n, 1'b1)
        foreach (a[i]) begin
            rd(a[i], q);
            `CHECK(q, 24'h00_0000)
        end
        $display("test reset values done");
    endtask : t_reset

    task automatic t_regs;
        logic [23:0] q;
        i_host.wr(ape_pkg::REG_MODE, 24'h12_8000);
        rd(ape_pkg::REG_MODE, q);
        `CHECK(q, 24'h00_8000)
        i_host.wr(ape_pkg::REG_WATT_GAIN, 24'hab_c800);
        rd(ape_pkg::REG_WATT_GAIN, q);
        `CHECK(q, 24'h00_0800)
        i_host.wr(ape_pkg::REG_ENERGY_DIV, 24'hab_00ff);
        rd(ape_pkg::REG_ENERGY_DIV, q);
        `CHECK(q, 24'h00_00ff)
        i_host.wr(ape_pkg::REG_POWER_OFFSET, 24'hab_8001);
        rd(ape_pkg::REG_POWER_OFFSET, q);
        `CHECK(q, 24'h00_8001)
        // negative offset under positive-only: energy must stay empty
        i_host.wr(ape_pkg::REG_ACTIVE_ENERGY, 24'h12_3456);
        rd(ape_pkg::REG_ACTIVE_ENERGY, q);
        `CHECK(q, 24'h00_0000)
        i_host.wr(ape_pkg::REG_POWER_OFFSET, 24'h00_0000);
        i_host.wr(ape_pkg::REG_MODE, 24'h00_0000);
        i_host.wr(ape_pkg::REG_WATT_GAIN, 24'h00_0000);
        i_host.wr(ape_pkg::REG_ENERGY_DIV, 24'h00_0000);
        $display("test register access done");
    endtask : t_regs

    task automatic t_offset;
        logic [15:0] o [3];
        logic [23:0] e [3];
        logic [23:0] q;
        o = '{16'h0100, 16'hff00, 16'h7f00};
        e = '{24'h00_0001, 24'hff_ffff, 24'h00_007f};
        i_host.wr(ape_pkg::REG_IRQ_ENABLE, 24'h00_0008);
        foreach (o[i]) begin
            i_host.wr(ape_pkg::REG_POWER_OFFSET, {8'h00, o[i]});
            rd(ape_pkg::REG_STATUS, q);
            wait_irq();
            rd(ape_pkg::REG_WAVEFORM, q);
            `CHECK(q, e[i])
        end
        i_host.wr(ape_pkg::REG_POWER_OFFSET, 24'h00_0000);
        $display("test power offset done");
    endtask : t_offset

    task automatic t_power;
        logic [11:0] g [3];
        logic [23:0] q;
        g = '{12'h000, 12'h7ff, 12'h800};
        @(posedge clk);
        current_sample <= 24'sh10_0000;
        voltage_sample <= 16'sh1000;
        foreach (g[i]) begin
            i_host.wr(ape_pkg::REG_WATT_GAIN, {12'h000, g[i]});
            repeat (400) @(posedge clk);
            rd(ape_pkg::REG_STATUS, q);
            wait_irq();
            rd(ape_pkg::REG_WAVEFORM, q);
            // filter settles from below to within three of the product
            `CHECK(in_rng(q, scale(65533, g[i]), scale(65536, g[i])), 1'b1)
        end
        current_sample <= 24'sh00_0000;
        voltage_sample <= 16'sh0000;
        i_host.wr(ape_pkg::REG_WATT_GAIN, 24'h00_0000);
        i_host.wr(ape_pkg::REG_IRQ_ENABLE, 24'h00_0000);
        repeat (400) @(posedge clk);
        $display("test active power done");
    endtask : t_power

    task automatic t_rate;
        logic [7:0]  d [2];
        logic [23:0] e1;
        logic [23:0] e2;
        longint      t;
        d = '{8'h00, 8'h04};
        i_host.wr(ape_pkg::REG_POWER_OFFSET, 24'h00_7fff);
        foreach (d[i]) begin
            i_host.wr(ape_pkg::REG_ENERGY_DIV, {16'h0000, d[i]});
            rd(ape_pkg::REG_ACTIVE_ENERGY, e1);
            rd(ape_pkg::REG_ENERGY_COR, e2);
            `CHECK(e2, e1)
            rd(ape_pkg::REG_ACTIVE_ENERGY, e2);
            `CHECK(in_rng(e2, 0, 1), 1'b1)
            // one sample every four clocks: 8192 ticks
            repeat (32768) @(posedge clk);
            rd(ape_pkg::REG_ACTIVE_ENERGY, e2);
            t = 32767 / ((d[i] == 8'h00) ? 1 : longint'(d[i]));
            `CHECK(in_rng(e2, (8190 * t) >> 25, ((8196 * t) >> 25) + 1), 1'b1)
        end
        i_host.wr(ape_pkg::REG_ENERGY_DIV, 24'h00_0000);
        $display("test accumulation rate done");
    endtask : t_rate

    task automatic t_posonly;
        logic [23:0] q;
        i_host.wr(ape_pkg::REG_MODE, 24'h00_8000);
        i_host.wr(ape_pkg::REG_POWER_OFFSET, 24'h00_8000);
        rd(ape_pkg::REG_ENERGY_COR, q);
        repeat (2000) @(posedge clk);
        rd(ape_pkg::REG_ACTIVE_ENERGY, q);
        `CHECK(q, 24'h00_0000)
        i_host.wr(ape_pkg::REG_MODE, 24'h00_0000);
        repeat (4400) @(posedge clk);
        rd(ape_pkg::REG_ACTIVE_ENERGY, q);
        `CHECK(in_rng(q, 24'hff_fffe, 24'hff_ffff), 1'b1)
        $display("test signed and positive-only done");
    endtask : t_posonly

    // ========================================================
    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_regs();
        t_offset();
        t_power();
        t_rate();
        t_posonly();
        summarize();
    end

endmodule : tb
